// ==== rcsp_pkg.sv ====
// rcsp_pkg: constants shared by the remote command serial port files.
// assumes a single 25 MHz device clock.
package rcsp_pkg;
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned BAUD_DEFAULT  = 9600;
  localparam int unsigned DATA_BITS     = 8;
  localparam int unsigned FRAME_BITS    = 10;
  localparam int unsigned OVERSAMPLE    = 16;
  localparam int unsigned MID_TICK      = 7;
  localparam int unsigned TCP_PORT      = 2101;
  localparam logic [7:0]  LEN_ZERO_HI   = 8'h00;
  localparam logic [2:0]  PROTO_RESET   = 3'h0;
  typedef enum logic [2:0] {
    RCSP_STANDARD,
    RCSP_DATALOG,
    RCSP_LEGACY_A_CHECKSUMMED,
    RCSP_LEGACY_A_PLAIN,
    RCSP_LEGACY_B_CHECKSUMMED,
    RCSP_LEGACY_B_PLAIN
  } rcsp_proto_t;
endpackage

// ==== rcsp_baud_gen.sv ====
// rcsp_baud_gen: one-cycle enable pulse at oversample rate.
// assumes div_i is at least 1 and held steady between frames.
`timescale 1ns/1ps
`default_nettype none
module rcsp_baud_gen #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] div_i,
  output logic              tick_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_q;
  logic         tick_d;

  always_comb begin
    if (cnt_q >= div_i - W'(1)) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end else begin
      cnt_d  = cnt_q + W'(1);
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;
endmodule // rcsp_baud_gen
`default_nettype wire

// ==== rcsp_serial_port.sv ====
// rcsp_serial_port: serial front end of the remote command interface.
// assumes a command engine behind the RX/TX byte ports; inputs synchronous to CLK_I.
`timescale 1ns/1ps
`default_nettype none
module rcsp_serial_port #(
  parameter int unsigned DIV_W = 16,
  parameter int unsigned BAUD  = rcsp_pkg::BAUD_DEFAULT
) (
  // clock and reset
  input  wire logic       CLK_I,
  input  wire logic       RST_N_I,
  // configuration
  input  wire logic [2:0] PROTO_SEL_I,
  // serial line, DCE view
  input  wire logic       HOST_TXD_I,
  output logic            HOST_RXD_O,
  // received bytes to the command engine
  output logic [7:0]      RX_DATA_O,
  output logic            RX_VALID_O,
  output logic            RX_FRAME_ERR_O,
  // message gating
  input  wire logic       MSG_END_I,
  input  wire logic       REPLY_DONE_I,
  output logic            MSG_BUSY_O,
  // bytes to send
  input  wire logic [7:0] TX_DATA_I,
  input  wire logic       TX_VALID_I,
  output logic            TX_READY_O,
  // active protocol
  output logic [2:0]      PROTO_O
);
  localparam int unsigned OS = rcsp_pkg::OVERSAMPLE;
  localparam logic [DIV_W-1:0] DIV =
    DIV_W'(rcsp_pkg::CLK_HZ / (BAUD * OS));

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rcsp_rx_t;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} rcsp_tx_t;

  logic tick;

  rcsp_baud_gen #(.W(DIV_W)) u_baud (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .div_i   (DIV),
    .tick_o  (tick)
  );

  // protocol register
  logic [2:0] proto_q;
  logic [2:0] proto_d;
  logic       datalog;

  always_comb begin
    proto_d = proto_q;
    if (PROTO_SEL_I <= 3'(rcsp_pkg::RCSP_LEGACY_B_PLAIN)) begin
      proto_d = PROTO_SEL_I;
    end
  end
  assign datalog = (proto_q == 3'(rcsp_pkg::RCSP_DATALOG));

  // receiver
  rcsp_rx_t   rx_st_q;
  rcsp_rx_t   rx_st_d;
  logic [3:0] rx_os_q;
  logic [3:0] rx_os_d;
  logic [2:0] rx_bit_q;
  logic [2:0] rx_bit_d;
  logic [7:0] rx_sh_q;
  logic [7:0] rx_sh_d;
  logic [7:0] rx_data_q;
  logic [7:0] rx_data_d;
  logic       rx_vld_q;
  logic       rx_vld_d;
  logic       rx_ferr_q;
  logic       rx_ferr_d;
  logic       busy_q;
  logic       busy_d;
  logic       mid;

  assign mid = tick && (rx_os_q == 4'(rcsp_pkg::MID_TICK));

  always_comb begin
    rx_st_d   = rx_st_q;
    rx_os_d   = rx_os_q;
    rx_bit_d  = rx_bit_q;
    rx_sh_d   = rx_sh_q;
    rx_data_d = rx_data_q;
    rx_vld_d  = 1'b0;
    rx_ferr_d = 1'b0;
    if (tick) begin
      rx_os_d = rx_os_q + 4'h1;
    end
    case (rx_st_q)
      RX_IDLE: begin
        rx_os_d = 4'h0;
        if (!HOST_TXD_I) begin
          rx_st_d = RX_START;
        end
      end
      RX_START: begin
        if (mid) begin
          rx_os_d = 4'h8;
          if (HOST_TXD_I) begin
            rx_st_d = RX_IDLE;
          end else begin
            rx_st_d  = RX_DATA;
            rx_bit_d = 3'h0;
          end
        end
      end
      RX_DATA: begin
        if (mid) begin
          rx_os_d = 4'h8;
          rx_sh_d = {HOST_TXD_I, rx_sh_q[7:1]};
          rx_bit_d = rx_bit_q + 3'h1;
          if (rx_bit_q == 3'(rcsp_pkg::DATA_BITS - 1)) begin
            rx_st_d = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (mid) begin
          rx_st_d = RX_IDLE;
          if (!HOST_TXD_I) begin
            rx_ferr_d = 1'b1;
          end else if (!datalog && !busy_q) begin
            rx_data_d = rx_sh_q;
            rx_vld_d  = 1'b1;
          end
        end
      end
      default: rx_st_d = RX_IDLE;
    endcase
  end

  // outside datalog, a message is closed by its last byte and held until answered
  always_comb begin
    busy_d = busy_q;
    if (MSG_END_I && !busy_q) begin
      busy_d = 1'b1;
    end else if (REPLY_DONE_I) begin
      busy_d = 1'b0;
    end
    if (datalog) begin
      busy_d = 1'b0;
    end
  end

  // transmitter: no clear-to-send gating
  rcsp_tx_t   tx_st_q;
  rcsp_tx_t   tx_st_d;
  logic [9:0] tx_sh_q;
  logic [9:0] tx_sh_d;
  logic [3:0] tx_os_q;
  logic [3:0] tx_os_d;
  logic [3:0] tx_cnt_q;
  logic [3:0] tx_cnt_d;
  logic       txd_q;
  logic       txd_d;
  logic       tx_rdy_q;
  logic       tx_rdy_d;

  always_comb begin
    tx_st_d  = tx_st_q;
    tx_sh_d  = tx_sh_q;
    tx_os_d  = tx_os_q;
    tx_cnt_d = tx_cnt_q;
    txd_d    = txd_q;
    tx_rdy_d = tx_rdy_q;
    case (tx_st_q)
      TX_IDLE: begin
        txd_d    = 1'b1;
        tx_rdy_d = 1'b1;
        if (TX_VALID_I && tx_rdy_q) begin
          tx_sh_d  = {1'b1, TX_DATA_I, 1'b0};
          tx_os_d  = 4'h0;
          tx_cnt_d = 4'h0;
          tx_rdy_d = 1'b0;
          tx_st_d  = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        txd_d = tx_sh_q[0];
        if (tick) begin
          tx_os_d = tx_os_q + 4'h1;
          if (tx_os_q == 4'(OS - 1)) begin
            tx_sh_d  = {1'b1, tx_sh_q[9:1]};
            tx_cnt_d = tx_cnt_q + 4'h1;
            if (tx_cnt_q == 4'(rcsp_pkg::FRAME_BITS - 1)) begin
              tx_st_d = TX_IDLE;
            end
          end
        end
      end
      default: tx_st_d = TX_IDLE;
    endcase
  end

  // protocol state
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      proto_q <= rcsp_pkg::PROTO_RESET;
    end else begin
      proto_q <= proto_d;
    end
  end

  // receiver state
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rx_st_q   <= RX_IDLE;
      rx_os_q   <= 4'h0;
      rx_bit_q  <= 3'h0;
      rx_sh_q   <= 8'h00;
      rx_data_q <= 8'h00;
      rx_vld_q  <= 1'b0;
      rx_ferr_q <= 1'b0;
    end else begin
      rx_st_q   <= rx_st_d;
      rx_os_q   <= rx_os_d;
      rx_bit_q  <= rx_bit_d;
      rx_sh_q   <= rx_sh_d;
      rx_data_q <= rx_data_d;
      rx_vld_q  <= rx_vld_d;
      rx_ferr_q <= rx_ferr_d;
    end
  end

  // message gate state
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  // transmitter state
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tx_st_q  <= TX_IDLE;
      tx_sh_q  <= 10'h3ff;
      tx_os_q  <= 4'h0;
      tx_cnt_q <= 4'h0;
      txd_q    <= 1'b1;
      tx_rdy_q <= 1'b0;
    end else begin
      tx_st_q  <= tx_st_d;
      tx_sh_q  <= tx_sh_d;
      tx_os_q  <= tx_os_d;
      tx_cnt_q <= tx_cnt_d;
      txd_q    <= txd_d;
      tx_rdy_q <= tx_rdy_d;
    end
  end

  // network port, its address and length bytes sit in the engine
  assign HOST_RXD_O     = txd_q;
  assign RX_DATA_O      = rx_data_q;
  assign RX_VALID_O     = rx_vld_q;
  assign RX_FRAME_ERR_O = rx_ferr_q;
  assign MSG_BUSY_O     = busy_q;
  assign TX_READY_O     = tx_rdy_q;
  assign PROTO_O        = proto_q;
endmodule // rcsp_serial_port
`default_nettype wire

// ==== rcsp_sva.sv ====
// rcsp_sva: port checks for rcsp_serial_port.
// assumes 16-cycle bits (BAUD 1562500 at 25 MHz).
`timescale 1ns/1ps
`default_nettype none
module rcsp_sva (
  // watched ports
  input wire logic       CLK_I,
  input wire logic       RST_N_I,
  input wire logic [2:0] PROTO_SEL_I,
  input wire logic       HOST_RXD_O,
  input wire logic       RX_VALID_O,
  input wire logic       RX_FRAME_ERR_O,
  input wire logic       MSG_END_I,
  input wire logic       MSG_BUSY_O,
  input wire logic       TX_VALID_I,
  input wire logic       TX_READY_O,
  input wire logic [2:0] PROTO_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_take; TX_VALID_I && TX_READY_O; endsequence
  // line output lags the take by two edges: ready drops first, start bit follows
  sequence s_start; !TX_READY_O ##1 (!TX_READY_O && !HOST_RXD_O); endsequence
  property p_start; s_take |=> s_start; endproperty
  a_start: assert property (p_start) else $error("no start bit");
  property p_stop; s_take |=> s_start ##[144:160] HOST_RXD_O; endproperty
  a_stop: assert property (p_stop) else $error("no stop bit");
  property p_ready; s_take |-> ##[155:170] TX_READY_O; endproperty
  a_ready: assert property (p_ready) else $error("tx never idle");
  property p_idle; TX_READY_O |-> HOST_RXD_O; endproperty
  a_idle: assert property (p_idle) else $error("idle line low");
  property p_busy; MSG_END_I && !MSG_BUSY_O && PROTO_O != 3'h1 |=> MSG_BUSY_O; endproperty
  a_busy: assert property (p_busy) else $error("busy not set");
  property p_drop; MSG_BUSY_O && $past(MSG_BUSY_O) |-> !RX_VALID_O; endproperty
  a_drop: assert property (p_drop) else $error("byte while busy");
  property p_dlog; PROTO_O == 3'h1 && $past(PROTO_O) == 3'h1 |-> !RX_VALID_O; endproperty
  a_dlog: assert property (p_dlog) else $error("byte in datalog");
  property p_proto; PROTO_SEL_I < 3'h6 |=> PROTO_O == $past(PROTO_SEL_I); endproperty
  a_proto: assert property (p_proto) else $error("proto not taken");
  property p_keep; PROTO_SEL_I > 3'h5 |=> $stable(PROTO_O); endproperty
  a_keep: assert property (p_keep) else $error("bad code taken");
  property p_excl; !(RX_VALID_O && RX_FRAME_ERR_O); endproperty
  a_excl: assert property (p_excl) else $error("valid with error");
endmodule // rcsp_sva
bind rcsp_serial_port rcsp_sva u_rcsp_sva (.CLK_I, .RST_N_I, .PROTO_SEL_I, .HOST_RXD_O,
  .RX_VALID_O, .RX_FRAME_ERR_O, .MSG_END_I, .MSG_BUSY_O, .TX_VALID_I, .TX_READY_O, .PROTO_O);
`default_nettype wire

// ==== rcsp_host_model.sv ====
// rcsp_host_model: host on the serial line, 16 cycles a bit.
// assumes the device line idles high.
`timescale 1ns/1ps
`default_nettype none
module rcsp_host_model (
  input  wire logic clk_i,
  input  wire logic dev_txd_i,
  output logic      host_txd_o,
  output logic [7:0] byte_o,
  output logic      stb_o
);
  initial begin
    host_txd_o = 1'b1;
    byte_o = 8'h00;
    stb_o = 1'b0;
  end
  // stp low sends a broken frame on request
  task automatic send(input logic [7:0] b, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_txd_o <= f[i];
      repeat (16) @(posedge clk_i);
    end
    host_txd_o <= 1'b1;
    repeat (32) @(posedge clk_i);
  endtask
  // receive on the device's transmit line
  always begin
    @(negedge dev_txd_i);
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge clk_i);
      byte_o[i] <= dev_txd_i;
    end
    repeat (16) @(posedge clk_i);
    stb_o <= dev_txd_i;
    @(posedge clk_i);
    stb_o <= 1'b0;
  end
endmodule // rcsp_host_model
`default_nettype wire

// ==== tb.sv ====
// tb: self-checking bench for rcsp_serial_port.
// assumes the host model and checker files compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk, rst_n, txd, rxd, rx_v, rx_fe, m_end, r_done, busy, tx_v, tx_rdy, h_stb;
  logic [2:0] sel, proto;
  logic [7:0] rx_d, tx_d, h_byte;
  logic [8:0] exp_q[$], hexp_q[$];
  int         error_cnt = 0, n_compared = 0, cyc = 0;
  rcsp_serial_port #(.BAUD(1562500)) u_rcsp_serial_port (.CLK_I(clk), .RST_N_I(rst_n),
    .PROTO_SEL_I(sel), .HOST_TXD_I(txd), .HOST_RXD_O(rxd), .RX_DATA_O(rx_d),
    .RX_VALID_O(rx_v), .RX_FRAME_ERR_O(rx_fe), .MSG_END_I(m_end), .REPLY_DONE_I(r_done),
    .MSG_BUSY_O(busy), .TX_DATA_I(tx_d), .TX_VALID_I(tx_v), .TX_READY_O(tx_rdy), .PROTO_O(proto));
  rcsp_host_model u_rcsp_host_model (.clk_i(clk), .dev_txd_i(rxd), .host_txd_o(txd),
    .byte_o(h_byte), .stb_o(h_stb));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(string nm, logic [8:0] e, logic [8:0] s);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  always @(negedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
    if (rx_v !== 1'b0 || rx_fe !== 1'b0)
      check("rx", exp_q.size() ? exp_q.pop_front() : 9'h1ff, rx_fe ? 9'h100 : {1'b0, rx_d});
    if (h_stb !== 1'b0)
      check("tx", hexp_q.size() ? hexp_q.pop_front() : 9'h1ff, {1'b0, h_byte});
  end
  task automatic send(logic [7:0] b, logic stp, logic ok);
    if (ok) exp_q.push_back(stp ? {1'b0, b} : 9'h100);
    u_rcsp_host_model.send(b, stp);
  endtask
  task automatic put(logic [7:0] b);
    @(posedge clk);
    hexp_q.push_back({1'b0, b});
    tx_d <= b;
    tx_v <= 1'b1;
    do @(negedge clk); while (tx_rdy !== 1'b1);
    @(posedge clk);
    tx_v <= 1'b0;
  endtask
  initial begin
    rst_n = 1'b0;
    sel = 3'h0;
    m_end = 1'b0;
    r_done = 1'b0;
    tx_v = 1'b0;
    tx_d = 8'h00;
    void'($urandom(32'hbb15ae09));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    send(8'h00, 1'b1, 1'b1);
    send(8'hff, 1'b1, 1'b1);
    repeat (6) send(8'($urandom), 1'b1, 1'b1);
    send(8'ha5, 1'b0, 1'b1);
    send(8'h0d, 1'b1, 1'b1);
    $display("test rx done");
    m_end <= 1'b1;
    @(posedge clk);
    m_end <= 1'b0;
    @(negedge clk);
    check("busy", 9'h001, {8'h00, busy});
    send(8'h3c, 1'b1, 1'b0);
    @(posedge clk);
    r_done <= 1'b1;
    @(posedge clk);
    r_done <= 1'b0;
    send(8'hc3, 1'b1, 1'b1);
    $display("test gating done");
    for (int i = 0; i < 8; i++) begin
      sel <= 3'(i);
      @(negedge clk);
      @(negedge clk);
      check("proto", 9'(i < 6 ? i : 5), {6'h00, proto});
      @(posedge clk);
    end
    sel <= 3'h1;
    send(8'h5a, 1'b1, 1'b0);
    put(8'h96);
    repeat (200) @(posedge clk);
    sel <= 3'h0;
    $display("test protocol done");
    repeat (3) put(8'($urandom));
    repeat (400) @(posedge clk);
    check("pending", 9'h000, 9'(exp_q.size() + hexp_q.size()));
    $display("test tx done");
    finish_test();
  end
endmodule // tb
`default_nettype wire
